// ---- core/pwmdb_pkg.sv ----
package pwmdb_pkg;
    localparam int NUM_GEN = 2;
    localparam int NUM_SIG = 4;
    localparam int CNT_W = 16;
    localparam int DB_W = 12;
    localparam int NUM_EVT = 6;
    // Event index within an action or interrupt-select vector
    localparam int EV_ZERO = 0;
    localparam int EV_LOAD = 1;
    localparam int EV_AUP = 2;
    localparam int EV_ADN = 3;
    localparam int EV_BUP = 4;
    localparam int EV_BDN = 5;
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_LOW = 2'h2;
    localparam logic [1:0] ACT_HIGH = 2'h3;
    localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
    localparam logic [DB_W-1:0] DB_ONE = 12'h001;

    typedef struct packed {
        logic enable;
        logic updown;
        logic load_sync;
        logic cmp_sync;
        logic dbg_run;
        logic db_enable;
        logic [CNT_W-1:0] load;
        logic [CNT_W-1:0] cmpa;
        logic [CNT_W-1:0] cmpb;
        logic [2*NUM_EVT-1:0] acta;
        logic [2*NUM_EVT-1:0] actb;
        logic [NUM_EVT-1:0] int_sel;
        logic [DB_W-1:0] db_rise;
        logic [DB_W-1:0] db_fall;
    } pwmdb_cfg_t;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic dir_up;
        logic [CNT_W-1:0] load;
        logic [CNT_W-1:0] cmpa;
        logic [CNT_W-1:0] cmpb;
        logic [CNT_W-1:0] load_pend;
        logic [CNT_W-1:0] cmpa_pend;
        logic [CNT_W-1:0] cmpb_pend;
        logic load_dirty;
        logic cmp_dirty;
        logic upd_req;
        logic sig_a;
        logic sig_b;
        logic [DB_W-1:0] rise_cnt;
        logic [DB_W-1:0] fall_cnt;
        logic db_a;
        logic db_b;
        logic stopped;
    } pwmdb_gen_t;

    typedef struct packed {
        pwmdb_gen_t [NUM_GEN-1:0] gen;
        logic [NUM_SIG-1:0] pins;
        logic [NUM_GEN-1:0] gen_irq;
        logic fault_irq;
    } pwmdb_state_t;
endpackage : pwmdb_pkg

// ---- core/pwmdb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
// Function
// - Counter gives one-cycle zero and load pulses plus direction, low counting down.
// - A compare value above the load value never matches.
// - Down mode reacts to zero, load, A-down and B-down.
// - Up/down mode adds A-up and B-up matches to those events.
// - Matches coinciding with zero or load are ignored.
// - Coinciding A and B: first output uses A action, second uses B.
// - Zero and load apply none, toggle, low or high per output; A matches act on the first output only, B on the second.
// - Dead-band off: both generator outputs pass unchanged.
// - Dead-band on: second output dropped, first output rising edge delayed.
// - Second dead-band output is inverted input, rising delayed after its fall.
// - Interrupt when any software-selected counter event occurs.
// - Interrupt timing comes from raw events, not dead-band edges.
// - Global reset clears selected counters together, synchronously.
// - Immediate mode: new load or compare takes effect at next zero.
// - Sync mode: value pending until update request, then at next zero.
// - Update request clears itself when applied; software cannot clear it.
// - Load and compare update mode chosen separately per generator.
// - Per-signal fault enable forces output inactive while fault input active.
// - A fault can raise a processor interrupt.
// - Debug stall: either keep running or count to zero and stop.
// - Debug stall never raises an interrupt.
// - Pin driven only when its bit in the enable word is set.
// - Optional per-signal final inversion makes the signal active low.
module pwmdb_top (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire pwmdb_pkg::pwmdb_cfg_t [pwmdb_pkg::NUM_GEN-1:0] cfg_i,
    input wire logic [pwmdb_pkg::NUM_GEN-1:0] load_wr_i,
    input wire logic [pwmdb_pkg::NUM_GEN-1:0] cmp_wr_i,
    input wire logic [pwmdb_pkg::NUM_GEN-1:0] upd_req_set_i,
    input wire logic [pwmdb_pkg::NUM_GEN-1:0] cnt_sync_i,
    input wire logic [pwmdb_pkg::NUM_SIG-1:0] out_enable_i,
    input wire logic [pwmdb_pkg::NUM_SIG-1:0] out_invert_i,
    input wire logic [pwmdb_pkg::NUM_SIG-1:0] fault_enable_i,
    input wire logic fault_i,
    input wire logic fault_int_en_i,
    input wire logic dbg_stall_i,
    output logic [pwmdb_pkg::NUM_SIG-1:0] pwm_o,
    output logic [pwmdb_pkg::NUM_GEN-1:0] gen_irq_o,
    output logic fault_irq_o,
    output logic [pwmdb_pkg::NUM_GEN-1:0] upd_pending_o,
    output logic [pwmdb_pkg::NUM_GEN*pwmdb_pkg::CNT_W-1:0] count_o
);
    pwmdb_pkg::pwmdb_state_t st_r;
    pwmdb_pkg::pwmdb_state_t st_nxt;
    logic [pwmdb_pkg::NUM_GEN-1:0][pwmdb_pkg::NUM_EVT-1:0] evt;
    logic [pwmdb_pkg::NUM_GEN-1:0] zero_p;
    logic [pwmdb_pkg::NUM_GEN-1:0] load_p;

    function automatic logic apply_act(input logic cur, input logic [1:0] act);
        logic r;
        r = cur;
        unique case (act)
            pwmdb_pkg::ACT_NONE: r = cur;
            pwmdb_pkg::ACT_TOGGLE: r = ~cur;
            pwmdb_pkg::ACT_LOW: r = 1'b0;
            pwmdb_pkg::ACT_HIGH: r = 1'b1;
        endcase
        return r;
    endfunction : apply_act

    // Dead-band counter: output rises only after input has been high delay cycles
    function automatic logic [pwmdb_pkg::DB_W-1:0] db_next(
        input logic in, input logic [pwmdb_pkg::DB_W-1:0] cnt
    );
        logic [pwmdb_pkg::DB_W-1:0] r;
        r = cnt;
        if (!in) begin
            r = '0;
        end else if (cnt != '1) begin
            r = cnt + pwmdb_pkg::DB_ONE;
        end
        return r;
    endfunction : db_next

    always_comb begin
        logic [pwmdb_pkg::NUM_EVT-1:0] ev;
        logic a_m;
        logic b_m;
        logic run;
        logic [1:0] aa;
        logic [1:0] ab;
        ev = '0;
        a_m = 1'b0;
        b_m = 1'b0;
        run = 1'b0;
        aa = '0;
        ab = '0;
        st_nxt = st_r;
        evt = '0;
        zero_p = '0;
        load_p = '0;
        for (int g = 0; g < pwmdb_pkg::NUM_GEN; g++) begin
            ev = '0;
            // Events decode from the current count, so each lasts one cycle
            zero_p[g] = cfg_i[g].enable && !st_r.gen[g].stopped
                && st_r.gen[g].cnt == '0;
            load_p[g] = cfg_i[g].enable && !st_r.gen[g].stopped
                && st_r.gen[g].cnt == st_r.gen[g].load;
            ev[pwmdb_pkg::EV_ZERO] = zero_p[g];
            ev[pwmdb_pkg::EV_LOAD] = load_p[g];
            // Count can start above a newly applied load, so values above load need the range check
            a_m = cfg_i[g].enable && st_r.gen[g].cmpa <= st_r.gen[g].load
                && st_r.gen[g].cnt == st_r.gen[g].cmpa;
            b_m = cfg_i[g].enable && st_r.gen[g].cmpb <= st_r.gen[g].load
                && st_r.gen[g].cnt == st_r.gen[g].cmpb;
            // A halted counter sits at zero and must not retrigger events
            if (zero_p[g] || load_p[g] || st_r.gen[g].stopped) begin
                a_m = 1'b0;
                b_m = 1'b0;
            end
            // Direction is only ever up in up/down mode
            ev[pwmdb_pkg::EV_ADN] = a_m && !st_r.gen[g].dir_up;
            ev[pwmdb_pkg::EV_BDN] = b_m && !st_r.gen[g].dir_up;
            ev[pwmdb_pkg::EV_AUP] = a_m && st_r.gen[g].dir_up;
            ev[pwmdb_pkg::EV_BUP] = b_m && st_r.gen[g].dir_up;
            evt[g] = ev;
            // Zero and load never share a cycle with a match, so A and B never
            // cross over; when zero and load coincide, the load action wins
            aa = '0;
            ab = '0;
            for (int e = 0; e < pwmdb_pkg::NUM_EVT; e++) begin
                if (ev[e] && !(e == pwmdb_pkg::EV_BUP
                        || e == pwmdb_pkg::EV_BDN)) begin
                    aa = cfg_i[g].acta[2*e +: 2];
                end
                if (ev[e] && !(e == pwmdb_pkg::EV_AUP
                        || e == pwmdb_pkg::EV_ADN)) begin
                    ab = cfg_i[g].actb[2*e +: 2];
                end
            end
            st_nxt.gen[g].sig_a = apply_act(st_r.gen[g].sig_a, aa);
            st_nxt.gen[g].sig_b = apply_act(st_r.gen[g].sig_b, ab);
            // Raw events only; stall blocks them
            st_nxt.gen_irq[g] = |(ev & cfg_i[g].int_sel)
                && !dbg_stall_i;
            // Pending values
            if (load_wr_i[g]) begin
                st_nxt.gen[g].load_pend = cfg_i[g].load;
                st_nxt.gen[g].load_dirty = 1'b1;
            end
            if (cmp_wr_i[g]) begin
                st_nxt.gen[g].cmpa_pend = cfg_i[g].cmpa;
                st_nxt.gen[g].cmpb_pend = cfg_i[g].cmpb;
                st_nxt.gen[g].cmp_dirty = 1'b1;
            end
            if (upd_req_set_i[g]) begin
                st_nxt.gen[g].upd_req = 1'b1;
            end
            if (zero_p[g]) begin
                if (st_r.gen[g].load_dirty && (!cfg_i[g].load_sync
                        || st_r.gen[g].upd_req)) begin
                    st_nxt.gen[g].load = st_r.gen[g].load_pend;
                    st_nxt.gen[g].load_dirty = load_wr_i[g];
                end
                if (st_r.gen[g].cmp_dirty && (!cfg_i[g].cmp_sync
                        || st_r.gen[g].upd_req)) begin
                    st_nxt.gen[g].cmpa = st_r.gen[g].cmpa_pend;
                    st_nxt.gen[g].cmpb = st_r.gen[g].cmpb_pend;
                    st_nxt.gen[g].cmp_dirty = cmp_wr_i[g];
                end
                // A new request in the same cycle survives the clear
                if (st_r.gen[g].upd_req && !upd_req_set_i[g]) begin
                    st_nxt.gen[g].upd_req = 1'b0;
                end
            end
            // Debug stall handling
            if (!dbg_stall_i) begin
                st_nxt.gen[g].stopped = 1'b0;
            end else if (!cfg_i[g].dbg_run && zero_p[g]) begin
                st_nxt.gen[g].stopped = 1'b1;
            end
            run = cfg_i[g].enable && !st_r.gen[g].stopped
                && !(dbg_stall_i && !cfg_i[g].dbg_run && zero_p[g]);
            if (run) begin
                if (!cfg_i[g].updown) begin
                    st_nxt.gen[g].dir_up = 1'b0;
                    st_nxt.gen[g].cnt = zero_p[g] ? st_r.gen[g].load
                        : st_r.gen[g].cnt - 16'h0001;
                end else if (st_r.gen[g].dir_up) begin
                    if (st_r.gen[g].cnt >= st_r.gen[g].load) begin
                        st_nxt.gen[g].dir_up = 1'b0;
                        st_nxt.gen[g].cnt = st_r.gen[g].cnt - 16'h0001;
                    end else begin
                        st_nxt.gen[g].cnt = st_r.gen[g].cnt + 16'h0001;
                    end
                end else begin
                    if (zero_p[g]) begin
                        st_nxt.gen[g].dir_up = 1'b1;
                        st_nxt.gen[g].cnt = 16'h0001;
                    end else begin
                        st_nxt.gen[g].cnt = st_r.gen[g].cnt - 16'h0001;
                    end
                end
            end
            if (cnt_sync_i[g]) begin
                st_nxt.gen[g].cnt = pwmdb_pkg::CNT_RESET;
                st_nxt.gen[g].dir_up = 1'b0;
            end
            // Dead-band stage, registered one cycle after the generator
            st_nxt.gen[g].rise_cnt = db_next(st_r.gen[g].sig_a,
                st_r.gen[g].rise_cnt);
            st_nxt.gen[g].fall_cnt = db_next(!st_r.gen[g].sig_a,
                st_r.gen[g].fall_cnt);
            if (cfg_i[g].db_enable) begin
                st_nxt.gen[g].db_a = st_r.gen[g].sig_a
                    && st_r.gen[g].rise_cnt >= cfg_i[g].db_rise;
                st_nxt.gen[g].db_b = !st_r.gen[g].sig_a
                    && st_r.gen[g].fall_cnt >= cfg_i[g].db_fall;
            end else begin
                st_nxt.gen[g].db_a = st_r.gen[g].sig_a;
                st_nxt.gen[g].db_b = st_r.gen[g].sig_b;
            end
            // Output control
            for (int s = 0; s < 2; s++) begin
                st_nxt.pins[2*g+s] = out_enable_i[2*g+s]
                    && ((((s == 0) ? st_r.gen[g].db_a : st_r.gen[g].db_b)
                    && !(fault_i && fault_enable_i[2*g+s]))
                    ^ out_invert_i[2*g+s]);
            end
        end
        st_nxt.fault_irq = fault_i && fault_int_en_i;
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_comb begin
        pwm_o = st_r.pins;
        gen_irq_o = st_r.gen_irq;
        fault_irq_o = st_r.fault_irq;
        for (int g = 0; g < pwmdb_pkg::NUM_GEN; g++) begin
            upd_pending_o[g] = st_r.gen[g].upd_req;
            count_o[g*pwmdb_pkg::CNT_W +: pwmdb_pkg::CNT_W] = st_r.gen[g].cnt;
        end
    end

    zero_pulse_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        zero_p[0] && cfg_i[0].enable && !dbg_stall_i && !cnt_sync_i[0]
        && st_r.gen[0].load != '0 |=> !zero_p[0])
        else $error("zero pulse longer than one cycle");
    cmp_range_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        st_r.gen[0].cmpa > st_r.gen[0].load
        |-> !evt[0][pwmdb_pkg::EV_ADN] && !evt[0][pwmdb_pkg::EV_AUP])
        else $error("match above load value");
    down_events_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        !cfg_i[0].updown && !st_r.gen[0].dir_up
        |-> !evt[0][pwmdb_pkg::EV_AUP] && !evt[0][pwmdb_pkg::EV_BUP])
        else $error("up match in down mode");
    match_ignore_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (zero_p[1] || load_p[1]) |-> evt[1][pwmdb_pkg::EV_BDN:
        pwmdb_pkg::EV_AUP] == '0)
        else $error("match not ignored on zero or load");
    gen_irq_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        |(evt[0] & cfg_i[0].int_sel) && !dbg_stall_i |=> gen_irq_o[0])
        else $error("selected event gave no interrupt");
    stall_irq_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        dbg_stall_i |=> !gen_irq_o[0] && !gen_irq_o[1])
        else $error("interrupt during stall");
    sync_clear_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        cnt_sync_i[1] |=> count_o[2*pwmdb_pkg::CNT_W-1:pwmdb_pkg::CNT_W]
        == '0)
        else $error("counter not cleared by sync");
    upd_hold_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        st_r.gen[0].upd_req && !zero_p[0] |=> st_r.gen[0].upd_req)
        else $error("update request dropped early");
    out_off_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        !out_enable_i[2] |=> !pwm_o[2])
        else $error("disabled pin driven");
    db_gap_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        cfg_i[0].db_enable && $past(cfg_i[0].db_enable)
        && cfg_i[0].db_rise != '0
        && cfg_i[0].db_fall != '0 |-> !(st_r.gen[0].db_a
        && st_r.gen[0].db_b))
        else $error("dead-band outputs overlap");
    sig_action_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        zero_p[0] && !load_p[0] && cfg_i[0].acta[1:0] == pwmdb_pkg::ACT_HIGH
        |=> st_r.gen[0].sig_a)
        else $error("zero action not applied");
    db_pass_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        !cfg_i[0].db_enable
        |=> st_r.gen[0].db_b == $past(st_r.gen[0].sig_b))
        else $error("bypassed dead-band changed signal");
    fault_force_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        fault_i && fault_enable_i[1] && !out_invert_i[1] |=> !pwm_o[1])
        else $error("fault did not force pin inactive");
    fault_irq_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        fault_i && fault_int_en_i |=> fault_irq_o)
        else $error("fault gave no interrupt");
    sequence upd_applied_s;
        st_r.gen[0].upd_req && zero_p[0] && !upd_req_set_i[0];
    endsequence
    upd_clear_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        upd_applied_s |=> !upd_pending_o[0])
        else $error("update request not cleared");
    sequence stall_zero_s;
        dbg_stall_i && !cfg_i[0].dbg_run && zero_p[0] && !cnt_sync_i[0];
    endsequence
    stall_stop_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        stall_zero_s ##1 dbg_stall_i
        |=> count_o[pwmdb_pkg::CNT_W-1:0] == '0)
        else $error("stalled counter moved");
endmodule : pwmdb_top
`default_nettype wire

// ---- testbench/pwmdb_gate_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module pwmdb_gate_model (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic high_i,
    input wire logic low_i,
    input wire logic armed_i,
    output logic shoot_o
);
    logic [2:0] arm_q;
    // Sticky, so a one-cycle overlap is not lost between checks
    // Pins lag the dead-band switch by two stages; wait the pipeline out
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            arm_q <= 3'h0;
            shoot_o <= 1'h0;
        end else begin
            arm_q <= {arm_q[1:0], armed_i};
            if (armed_i && arm_q[2] && high_i && low_i) begin
                shoot_o <= 1'h1;
            end
        end
    end
endmodule : pwmdb_gate_model
`default_nettype wire

// ---- testbench/pwm_generator_deadband_output_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
module pwm_generator_deadband_output_bench;
    logic sys_clk_i;
    logic nrst_i;
    pwmdb_pkg::pwmdb_cfg_t [pwmdb_pkg::NUM_GEN-1:0] cfg;
    logic [1:0] load_wr, cmp_wr, upd_set, cnt_sync, irq, pend;
    logic [3:0] oen, inv, fen, pwm;
    logic fault, fault_ie, stall, fault_irq, shoot;
    logic [31:0] count;
    int miscompares;
    int checked;
    int hi [4];
    int nirq [2];
    logic [15:0] c1;
    pwmdb_top dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .cfg_i(cfg),
        .load_wr_i(load_wr), .cmp_wr_i(cmp_wr), .upd_req_set_i(upd_set),
        .cnt_sync_i(cnt_sync), .out_enable_i(oen), .out_invert_i(inv),
        .fault_enable_i(fen), .fault_i(fault), .fault_int_en_i(fault_ie),
        .dbg_stall_i(stall), .pwm_o(pwm), .gen_irq_o(irq),
        .fault_irq_o(fault_irq), .upd_pending_o(pend), .count_o(count));
    pwmdb_gate_model gates (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
        .high_i(pwm[0]), .low_i(pwm[1]), .armed_i(cfg[0].db_enable),
        .shoot_o(shoot));
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %0d seen %0d", n, e, g);
        end
    endtask : chk
    // High-cycle counts over whole periods are immune to pipeline phase
    task automatic run(input int n);
        repeat (30) @(posedge sys_clk_i);
        hi = '{default: 0};
        nirq = '{default: 0};
        repeat (n) begin
            @(negedge sys_clk_i);
            for (int i = 0; i < 4; i++) hi[i] += (pwm[i] === 1'h1);
            for (int i = 0; i < 2; i++) nirq[i] += (irq[i] === 1'h1);
        end
    endtask : run
    task automatic wr(input int g);
        @(posedge sys_clk_i);
        load_wr <= 2'h1 << g;
        cmp_wr <= 2'h1 << g;
        @(posedge sys_clk_i);
        load_wr <= 2'h0;
        cmp_wr <= 2'h0;
    endtask : wr
    initial begin
        sys_clk_i = 1'h0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    initial begin
        #200000;
        miscompares++;
        report_and_stop();
    end
    initial begin
        cfg = '0;
        {load_wr, cmp_wr, upd_set, cnt_sync} = '0;
        {oen, inv, fen, fault, fault_ie, stall} = '0;
        nrst_i = 1'h0;
        repeat (10) @(posedge sys_clk_i);
        nrst_i <= 1'h1;
        @(posedge sys_clk_i);
        cfg[0].load <= 16'h0009;
        cfg[0].cmpa <= 16'h0004;
        cfg[0].cmpb <= 16'h0007;
        cfg[0].acta <= 12'h083;
        cfg[0].actb <= 12'h803;
        cfg[1].load <= 16'h0004;
        cfg[1].cmpa <= 16'h0002;
        cfg[1].acta <= 12'h083;
        cfg[1].actb <= 12'h001;
        cfg[0].int_sel <= 6'h01;
        cfg[1].int_sel <= 6'h01;
        cfg[0].enable <= 1'h1;
        cfg[1].enable <= 1'h1;
        oen <= 4'hf;
        wr(0);
        wr(1);
        run(100);
        chk("pin0", 60, hi[0]);
        chk("pin1", 30, hi[1]);
        chk("pin2", 60, hi[2]);
        chk("pin3", 50, hi[3]);
        chk("irq0", 10, nirq[0]);
        chk("irq1", 20, nirq[1]);
        $display("test down_mode done");
        cfg[0].cmpa <= 16'h0009;
        cfg[0].cmpb <= 16'h000a;
        wr(0);
        run(100);
        chk("pin0", 100, hi[0]);
        chk("pin1", 100, hi[1]);
        $display("test ignored_match done");
        cfg[0].cmpa <= 16'h0004;
        cfg[0].cmpb <= 16'h0004;
        cfg[0].acta <= 12'h8c2;
        cfg[0].actb <= 12'hc82;
        wr(0);
        run(100);
        chk("pin0", 40, hi[0]);
        chk("pin1", 40, hi[1]);
        $display("test coincide done");
        cfg[0].acta <= 12'h083;
        cfg[0].db_enable <= 1'h1;
        cfg[0].db_rise <= 12'h002;
        cfg[0].db_fall <= 12'h001;
        run(100);
        chk("pin0", 40, hi[0]);
        chk("pin1", 30, hi[1]);
        chk("shoot", 0, shoot);
        $display("test dead_band done");
        cfg[0].db_enable <= 1'h0;
        inv <= 4'h1;
        fen <= 4'h2;
        fault <= 1'h1;
        fault_ie <= 1'h1;
        oen <= 4'hb;
        run(100);
        chk("pin0", 40, hi[0]);
        chk("pin1", 0, hi[1]);
        chk("pin2", 0, hi[2]);
        chk("fault_irq", 1, fault_irq);
        $display("test output_stage done");
        {inv, fen, fault} <= '0;
        oen <= 4'hf;
        cfg[0].load <= 16'h0004;
        cfg[0].cmpa <= 16'h0002;
        wr(0);
        run(100);
        chk("irq0", 20, nirq[0]);
        chk("pin0", 60, hi[0]);
        cfg[0].load_sync <= 1'h1;
        cfg[0].load <= 16'h0009;
        cfg[0].cmpa <= 16'h0001;
        wr(0);
        run(100);
        chk("irq0", 20, nirq[0]);
        chk("pin0", 80, hi[0]);
        chk("pend", 0, pend[0]);
        cfg[0].cmp_sync <= 1'h1;
        cfg[0].cmpa <= 16'h0003;
        wr(0);
        run(100);
        chk("pin0", 80, hi[0]);
        @(posedge sys_clk_i);
        upd_set <= 2'h1;
        @(posedge sys_clk_i);
        upd_set <= 2'h0;
        @(negedge sys_clk_i);
        chk("pend", 1, pend[0]);
        run(100);
        chk("pend", 0, pend[0]);
        chk("irq0", 10, nirq[0]);
        chk("pin0", 70, hi[0]);
        $display("test update done");
        cfg[1].load <= 16'h0009;
        wr(1);
        repeat (30) @(posedge sys_clk_i);
        cnt_sync <= 2'h3;
        @(posedge sys_clk_i);
        cnt_sync <= 2'h0;
        repeat (3) @(negedge sys_clk_i);
        chk("sync", 0, count[15:0] ^ count[31:16]);
        $display("test sync done");
        cfg[1].updown <= 1'h1;
        cfg[1].load <= 16'h0004;
        cfg[1].acta <= 12'h0b0;
        cfg[1].int_sel <= 6'h04;
        wr(1);
        run(96);
        chk("pin2", 48, hi[2]);
        chk("irq1", 12, nirq[1]);
        $display("test up_down done");
        cfg[0].int_sel <= 6'h3f;
        cfg[1].dbg_run <= 1'h1;
        stall <= 1'h1;
        run(50);
        chk("irq0", 0, nirq[0]);
        chk("irq1", 0, nirq[1]);
        chk("count0", 0, count[15:0]);
        c1 = count[31:16];
        @(negedge sys_clk_i);
        chk("count1", 1, count[31:16] != c1);
        $display("test stall done");
        report_and_stop();
    end
endmodule : pwm_generator_deadband_output_bench
`default_nettype wire
